// >>> logic/pcm_pkg.sv
// Shared types and constants of the serial audio port datapath.
// Assumes one system clock; the bit clock and frame clock arrive as pins.
package pcm_pkg;

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int SENSE_W = 16;
  localparam int SLOT_BITS = 8;
  localparam int SLOT_SHIFT = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int N_TYPES = 7;
  localparam int RATIO_W = 10;

  // Transmit word type indexes.
  localparam int TY_VOLT = 0;
  localparam int TY_CURR = 1;
  localparam int TY_DSP = 2;
  localparam int TY_ATTN = 3;
  localparam int TY_VBAT = 4;
  localparam int TY_SUPPLY = 5;
  localparam int TY_STATUS = 6;

  // Reset values of the link state.
  localparam logic [RATIO_W-1:0] BIT_RESET = 10'h000;
  localparam logic [1:0] SKIP_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_I2S, FMT_LEFT, FMT_TDM0, FMT_TDM1, FMT_TDM2
  } pcm_format_t;

  typedef enum logic [1:0] {WS16, WS24, WS32} word_size_t;

  typedef struct packed {
    logic thermal_warn_begin;
    logic thermal_warn_end;
    logic foldback_begin;
    logic foldback_end;
    logic headroom_active_end;
    logic headroom_active_begin;
    logic speaker_overcurrent;
    logic powerup_done;
  } status_byte_t;

  typedef struct packed {
    logic [15:0] voltage_sense_word;
    logic [15:0] current_sense_word;
    logic [31:0] dsp_monitor_word;
    logic [15:0] headroom_attenuation_word;
    logic [15:0] battery_voltage_word;
    logic [15:0] supply_voltage_word;
    status_byte_t status;
  } tx_words_t;

  typedef struct packed {
    logic [N_TYPES-1:0] enable;
    logic [N_TYPES-1:0][5:0] slot;
  } tx_config_t;

  // Drive controls: 1 selects high impedance, 0 selects zero code.
  typedef struct packed {
    pcm_format_t format;
    logic frame_edge_select;
    logic bit_clock_edge_select;
    word_size_t channel_word_size;
    logic [RATIO_W-1:0] clock_ratio_select;
    logic [3:0] playback_source;
    logic rx_enable;
    logic tx_enable;
    logic idle_slot_drive;
    logic extra_bit_drive;
    logic sense_interleave_mode;
  } port_config_t;

endpackage

// >>> logic/pcm_tdm_port_datapath.sv
// Serial audio port datapath: frame timing, playback channel pick, transmit slots.
// Assumes the host drives bit clock and frame clock; both are sampled here.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------
module pcm_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (s_q.wr[AW] == s_q.rd[AW]) || (s_q.wr[AW-1:0] != s_q.rd[AW-1:0]);
  assign out_valid = s_q.wr != s_q.rd;
  assign out_data = mem[s_q.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[s_q.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// Port datapath
// ------------------------------------------------------------------
module pcm_tdm_port_datapath (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial pins
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Configuration and transmit sources
  input wire pcm_pkg::port_config_t cfg,
  input wire pcm_pkg::tx_config_t tx_cfg,
  input wire pcm_pkg::tx_words_t tx_words,
  // Playback stream
  output logic [pcm_pkg::WORD_W-1:0] playback_data,
  output logic playback_valid,
  input wire logic playback_ready,
  output logic rx_overflow
);
  import pcm_pkg::*;

  typedef struct packed {
    logic bclk_s1, bclk_s2, bclk_s3;
    logic fclk_s1, fclk_s2, fclk_s3;
    logic din_s1, din_s2;
    logic running;
    logic [1:0] skip;
    logic [RATIO_W-1:0] bit_pos;
    logic [RATIO_W-1:0] ch_bit;
    logic [3:0] ch_idx;
    logic [WORD_W-1:0] rx_shift;
    logic odd_frame;
    tx_words_t snap;
    logic [SENSE_W-1:0] curr_hold;
    logic dout, dout_en;
    logic pend_valid;
    logic [WORD_W-1:0] pend_data;
    logic play_valid;
    logic [WORD_W-1:0] play_data;
    logic overflow;
  } port_state_t;

  port_state_t s_q, s_d;
  logic fifo_in_ready, fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] word_bits(input word_size_t ws);
    unique case (ws)
      WS16: word_bits = 6'h10;
      WS24: word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction

  function automatic logic is_tdm(input pcm_format_t f);
    is_tdm = (f == FMT_TDM0) || (f == FMT_TDM1) || (f == FMT_TDM2);
  endfunction

  // Edges to skip after sync before the first bit is latched.
  function automatic logic [1:0] latch_skip(input pcm_format_t f);
    unique case (f)
      FMT_I2S, FMT_TDM1: latch_skip = 2'h1;
      FMT_TDM2: latch_skip = 2'h2;
      default: latch_skip = 2'h0;
    endcase
  endfunction

  function automatic logic [RATIO_W-1:0] channel_len(input port_config_t c);
    if (is_tdm(c.format)) begin
      channel_len = {4'h0, word_bits(c.channel_word_size)};
    end else begin
      channel_len = {1'b0, c.clock_ratio_select[RATIO_W-1:1]};
    end
  endfunction

  // Word of a type, MSB aligned to bit 31, with its width in bits.
  function automatic logic [37:0] type_word(input int k, input tx_words_t w);
    unique case (k)
      TY_VOLT: type_word = {6'h10, w.voltage_sense_word, 16'h0000};
      TY_CURR: type_word = {6'h10, w.current_sense_word, 16'h0000};
      TY_DSP: type_word = {6'h20, w.dsp_monitor_word};
      TY_ATTN: type_word = {6'h10, w.headroom_attenuation_word, 16'h0000};
      TY_VBAT: type_word = {6'h10, w.battery_voltage_word, 16'h0000};
      TY_SUPPLY: type_word = {6'h10, w.supply_voltage_word, 16'h0000};
      default: type_word = {6'h08, w.status, 24'h000000};
    endcase
  endfunction

  // Returns {drive, value} for the bit at the given frame or channel position.
  function automatic logic [1:0] tx_bit(input port_config_t c, input tx_config_t t, input tx_words_t w,
                                        input logic [15:0] curr, input logic odd,
                                        input logic [RATIO_W-1:0] pos, input logic [RATIO_W-1:0] chb,
                                        input logic [3:0] chi);
    logic tdm, shared, inter, hit, pad, val;
    logic [37:0] tw;
    logic [31:0] word;
    int rel, width, limit;
    tdm = is_tdm(c.format);
    shared = t.enable[TY_VOLT] && t.enable[TY_CURR] && (t.slot[TY_VOLT] == t.slot[TY_CURR]);
    inter = shared && c.sense_interleave_mode;
    hit = 1'b0;
    pad = 1'b0;
    val = 1'b0;
    for (int k = 0; k < N_TYPES; k++) begin
      tw = type_word(k, w);
      word = tw[31:0];
      width = int'(tw[37:32]);
      if (inter && k == TY_VOLT) begin
        word = odd ? {1'b1, curr[15:1], 16'h0000} : {1'b0, w.voltage_sense_word[15:1], 16'h0000};
      end
      if (tdm) begin
        rel = int'(pos) - int'(t.slot[k]) * SLOT_BITS;
        limit = width;
      end else begin
        rel = (t.slot[k][0] == chi[0] && chi[3:1] == 3'h0) ? int'(chb) : -1;
        limit = (width < int'(word_bits(c.channel_word_size))) ? width : int'(word_bits(c.channel_word_size));
      end
      if (shared && !inter && k == TY_CURR) begin
        rel = rel - SENSE_W;
      end
      if (t.enable[k] && !(inter && k == TY_CURR) && (tdm || k <= TY_DSP) && rel >= 0) begin
        if (rel < limit && !hit) begin
          hit = 1'b1;
          val = word[31 - rel];
        end else if (!tdm || inter) begin
          pad = 1'b1;
        end
      end
    end
    if (!c.tx_enable) begin
      tx_bit = 2'b00;
    end else if (hit) begin
      tx_bit = {1'b1, val};
    end else if (pad) begin
      tx_bit = {!c.extra_bit_drive, 1'b0};
    end else begin
      tx_bit = {!c.idle_slot_drive, 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------
  // Playback buffer
  // ----------------------------------------------------------------
  pcm_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) playback_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(s_q.pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(s_q.pend_data),
    .out_valid(fifo_out_valid),
    .out_ready(!s_q.play_valid || playback_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Link logic
  // ----------------------------------------------------------------
  always_comb begin
    logic active_edge, frame_edge, frame_start, tdm, emit;
    logic [1:0] txb;
    logic [RATIO_W-1:0] clen;
    logic [5:0] wbits;
    logic [WORD_W-1:0] aligned;
    s_d = s_q;
    tdm = is_tdm(cfg.format);
    clen = channel_len(cfg);
    wbits = word_bits(cfg.channel_word_size);
    aligned = '0;
    emit = 1'b0;
    txb = 2'b00;
    if (fifo_in_ready) begin
      s_d.pend_valid = 1'b0;
    end
    s_d.bclk_s1 = bit_clock_in;
    s_d.bclk_s2 = s_q.bclk_s1;
    s_d.bclk_s3 = s_q.bclk_s2;
    s_d.fclk_s1 = frame_clock_in;
    s_d.fclk_s2 = s_q.fclk_s1;
    s_d.fclk_s3 = s_q.fclk_s2;
    s_d.din_s1 = serial_data_in;
    s_d.din_s2 = s_q.din_s1;
    active_edge = (s_q.bclk_s2 != s_q.bclk_s3) && (s_q.bclk_s2 == !cfg.bit_clock_edge_select);
    frame_edge = s_q.fclk_s2 != s_q.fclk_s3;
    frame_start = frame_edge && (tdm ? (s_q.fclk_s2 != cfg.frame_edge_select)
                                     : (s_q.fclk_s2 == cfg.frame_edge_select));

    // Received bits shift on the active edge; the sync edge lines up counters, takes the transmit words and sets the output bit.
    if (active_edge && s_q.running) begin
      emit = 1'b1;
      if (s_q.skip != 2'h0) begin
        s_d.skip = s_q.skip - 2'h1;
      end else begin
        if (s_q.ch_bit < {4'h0, wbits}) begin
          s_d.rx_shift = {s_q.rx_shift[WORD_W-2:0], s_q.din_s2};
        end
        s_d.bit_pos = s_q.bit_pos + 1'b1;
        if (s_q.ch_bit == clen - 1'b1) begin
          aligned = s_d.rx_shift << (6'h20 - wbits);
          if (s_q.ch_idx == cfg.playback_source) begin
            if (s_q.pend_valid && !fifo_in_ready) begin
              s_d.overflow = 1'b1;
            end
            s_d.pend_data = cfg.rx_enable ? aligned : '0;
            s_d.pend_valid = 1'b1;
          end
          s_d.ch_bit = '0;
          s_d.ch_idx = s_q.ch_idx + 4'h1;
          if (!tdm) begin
            s_d.running = 1'b0;
          end
        end else begin
          s_d.ch_bit = s_q.ch_bit + 1'b1;
        end
        if (s_q.bit_pos == cfg.clock_ratio_select - 1'b1) begin
          s_d.running = 1'b0;
        end
      end
    end
    // Each channel edge in two-channel formats restarts the channel count.
    if (frame_start || (frame_edge && !tdm)) begin
      emit = 1'b1;
      s_d.running = 1'b1;
      s_d.skip = latch_skip(cfg.format);
      s_d.ch_bit = '0;
      s_d.ch_idx = frame_start ? 4'h0 : 4'h1;
      s_d.bit_pos = frame_start ? BIT_RESET : {1'b0, cfg.clock_ratio_select[RATIO_W-1:1]};
    end
    if (frame_start) begin
      s_d.odd_frame = cfg.sense_interleave_mode && !s_q.odd_frame;
      s_d.snap = tx_words;
      if (!s_d.odd_frame) begin
        s_d.curr_hold = tx_words.current_sense_word;
      end
    end

    // Present the bit that the next active edge samples.
    if (emit) begin
      if (s_d.running && s_d.skip == 2'h0 && (s_d.bit_pos >> SLOT_SHIFT) < (cfg.clock_ratio_select >> SLOT_SHIFT)) begin
        txb = tx_bit(cfg, tx_cfg, s_d.snap, s_d.curr_hold, s_d.odd_frame, s_d.bit_pos, s_d.ch_bit, s_d.ch_idx);
      end else if (cfg.tx_enable) begin
        txb = {!cfg.idle_slot_drive, 1'b0};
      end
      s_d.dout_en = txb[1];
      s_d.dout = txb[0];
    end

    if (!s_q.play_valid || playback_ready) begin
      s_d.play_valid = fifo_out_valid;
      s_d.play_data = fifo_out_valid ? fifo_out_data : s_q.play_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_data_out = s_q.dout;
  assign serial_data_oe = s_q.dout_en;
  assign playback_data = s_q.play_data;
  assign playback_valid = s_q.play_valid;
  assign rx_overflow = s_q.overflow;
endmodule

// >>> verification/pcm_host_model.sv
// Host model: makes bit and frame clocks, sends BITS bits per call and captures the reply.
// Rising bit clock is active; frame edges sit on falling bit clock edges.
`timescale 1ns/1ps
module pcm_host_model #(
  parameter int HALF_NS = 40,
  parameter int BITS = 128
) (
  // Clocks made by the host
  output logic bit_clock,
  output logic frame_clock,
  // Data lines
  output logic data_to_dev,
  input wire logic data_from_dev,
  input wire logic oe_from_dev
);
  logic [BITS-1:0] rx_bits;
  logic [BITS-1:0] rx_oe;
  // A nonzero half_len makes a two-channel frame clock that toggles every half_len bits.
  int half_len = 0;
  // Clocks stand still between frames.
  initial begin
    bit_clock = 1'b0;
    frame_clock = 1'b0;
    data_to_dev = 1'b0;
  end
  // Lat adds idle active edges before the first bit, as the delayed formats expect.
  task automatic run_frame(input logic [BITS-1:0] tx, input logic inv, input int lat);
    frame_clock = inv;
    #HALF_NS;
    for (int i = 0; i < BITS + lat; i++) begin
      frame_clock = inv ^ ((half_len > 0) ? ((i / half_len) % 2 == 0) : (i == 0));
      if (i >= lat) data_to_dev = tx[BITS-1-i+lat];
      #HALF_NS bit_clock = 1'b1;
      if (i >= lat) rx_bits[BITS-1-i+lat] = data_from_dev;
      if (i >= lat) rx_oe[BITS-1-i+lat] = oe_from_dev;
      #HALF_NS bit_clock = 1'b0;
    end
    frame_clock = inv;
    // A released line flips, so a stale bit is never read as a fresh one.
    data_to_dev = ~data_to_dev;
  endtask
endmodule

// >>> verification/pcm_tdm_port_datapath_asserts.sv
// Checker of the port datapath pins and playback stream.
// Bound to the datapath; it sees the datapath ports only.
`timescale 1ns/1ps
module pcm_tdm_port_datapath_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial pins
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  // Configuration and sources
  input wire pcm_pkg::port_config_t cfg,
  input wire pcm_pkg::tx_config_t tx_cfg,
  input wire pcm_pkg::tx_words_t tx_words,
  // Playback stream
  input wire logic [pcm_pkg::WORD_W-1:0] playback_data,
  input wire logic playback_valid,
  input wire logic playback_ready,
  input wire logic rx_overflow
);
  import pcm_pkg::*;
  logic [3:0] quiet_q;
  logic st0;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Cycles since a clock pin moved; the serial output may only move shortly after one.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= 4'h0;
    end else if ($changed(bit_clock_in) || $changed(frame_clock_in)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  assign st0 = cfg.format == FMT_TDM0 && cfg.tx_enable && tx_cfg.enable[TY_STATUS] && tx_cfg.slot[TY_STATUS] == 6'h00;
  chk_reset_quiet: assert property (
    $rose(resetn) |-> !serial_data_oe && !playback_valid)
    else $error("outputs not quiet after reset");
  chk_valid_hold: assert property (
    playback_valid && !playback_ready |=> playback_valid && $stable(playback_data))
    else $error("playback word changed before accept");
  chk_out_timing: assert property (
    $changed(serial_data_out) || $changed(serial_data_oe) |-> quiet_q inside {[4'h1:4'h6]})
    else $error("serial output moved away from a clock edge");
  chk_rx_off_zero: assert property (
    playback_valid && !cfg.rx_enable |-> playback_data == '0)
    else $error("playback not zero with receive off");
  chk_word_size: assert property (
    playback_valid && cfg.channel_word_size == WS16 |-> playback_data[15:0] == 16'h0000)
    else $error("bits below word size not zero");
  chk_idle_hiz: assert property (
    $rose(serial_data_oe) |-> !(cfg.idle_slot_drive && tx_cfg.enable == 7'h00))
    else $error("output driven with nothing to send");
  chk_first_rise: assert property (
    st0 && !cfg.frame_edge_select && $rose(frame_clock_in) |-> ##[3:6]
    serial_data_oe && serial_data_out == tx_words.status.thermal_warn_begin)
    else $error("first bit missing after rising sync");
  chk_first_fall: assert property (
    st0 && cfg.frame_edge_select && $fell(frame_clock_in) |-> ##[3:6]
    serial_data_oe && serial_data_out == tx_words.status.thermal_warn_begin)
    else $error("first bit missing after falling sync");
  cover property (playback_valid && playback_ready);
  cover property ($fell(frame_clock_in) && cfg.frame_edge_select);
  cover property (serial_data_oe && cfg.sense_interleave_mode);
  cover property ($rose(rx_overflow));
endmodule

bind pcm_tdm_port_datapath pcm_tdm_port_datapath_asserts chk (.clock, .resetn, .bit_clock_in, .frame_clock_in,
  .serial_data_in, .serial_data_out, .serial_data_oe, .cfg, .tx_cfg, .tx_words, .playback_data, .playback_valid,
  .playback_ready, .rx_overflow);

// >>> verification/pcm_tdm_port_datapath_tb.sv
// Self-checking bench of the serial audio port datapath.
// A host model makes the link clocks; the bench drives configuration and playback.
`timescale 1ns/1ps
module pcm_tdm_port_datapath_tb;
  import pcm_pkg::*;
  localparam int BITS = 128;
  localparam logic [BITS-1:0] DIN = {16'h1111, 16'h9C35, 96'h0};
  localparam logic [WORD_W-1:0] PB_WORD = 32'h9C350000;
  logic clock, resetn, bclk, fclk, sdin, sdout, sdoe;
  port_config_t cfg;
  tx_config_t tx_cfg;
  tx_words_t tx_words;
  logic [WORD_W-1:0] playback_data;
  logic playback_valid, playback_ready, rx_overflow;
  int num_errors;
  int n_tests;
  pcm_tdm_port_datapath dut (.clock, .resetn, .bit_clock_in(bclk), .frame_clock_in(fclk), .serial_data_in(sdin),
    .serial_data_out(sdout), .serial_data_oe(sdoe), .cfg, .tx_cfg, .tx_words, .playback_data, .playback_valid,
    .playback_ready, .rx_overflow);
  pcm_host_model #(.HALF_NS(40), .BITS(BITS)) host (.bit_clock(bclk), .frame_clock(fclk), .data_to_dev(sdin),
    .data_from_dev(sdout), .oe_from_dev(sdoe));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic cmp_val(input string what, input logic [BITS-1:0] exp, input logic [BITS-1:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [BITS-1:0] exp_frame();
    return {tx_words.status, tx_words.voltage_sense_word, tx_words.current_sense_word, tx_words.dsp_monitor_word,
      tx_words.headroom_attenuation_word, tx_words.battery_voltage_word, tx_words.supply_voltage_word, 8'h00};
  endfunction
  // The consumer stalls two cycles before it accepts each word.
  task automatic pop_word(input logic [WORD_W-1:0] exp);
    int k;
    k = 0;
    while (playback_valid !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    repeat (2) @(negedge clock);
    cmp_val("playback valid", 128'h1, {127'h0, playback_valid});
    cmp_val("playback", {96'h0, exp}, {96'h0, playback_data});
    playback_ready = 1'b1;
    @(negedge clock);
    playback_ready = 1'b0;
  endtask
  task automatic set_base();
    cfg = '0;
    cfg.format = FMT_TDM0;
    cfg.channel_word_size = WS16;
    cfg.clock_ratio_select = 10'h080;
    cfg.playback_source = 4'h1;
    cfg.rx_enable = 1'b1;
    cfg.tx_enable = 1'b1;
    tx_cfg.enable = 7'h7F;
    tx_cfg.slot = {6'h00, 6'h0D, 6'h0B, 6'h09, 6'h05, 6'h03, 6'h01};
  endtask
  task automatic t_formats();
    pcm_format_t fmts [3];
    fmts = '{FMT_TDM0, FMT_TDM1, FMT_TDM2};
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      cfg.format = fmts[k];
      host.run_frame(DIN, 1'b0, k);
      cmp_val("slot map", exp_frame(), host.rx_bits);
      cmp_val("slot drive", '1, host.rx_oe);
      pop_word(PB_WORD);
    end
    cfg.format = FMT_TDM0;
  endtask
  task automatic t_idle_hiz();
    logic [BITS-1:0] m;
    m = {24'hFFFFFF, 48'h0, 48'hFFFFFFFFFFFF, 8'h00};
    @(negedge clock);
    cfg.idle_slot_drive = 1'b1;
    tx_cfg.enable[TY_CURR] = 1'b0;
    tx_cfg.enable[TY_DSP] = 1'b0;
    host.run_frame(DIN, 1'b0, 0);
    cmp_val("idle drive", m, host.rx_oe);
    cmp_val("driven slots", exp_frame() & m, host.rx_bits & m);
    pop_word(PB_WORD);
    set_base();
  endtask
  task automatic t_edge_invert();
    @(negedge clock);
    cfg.frame_edge_select = 1'b1;
    host.run_frame(DIN, 1'b1, 0);
    cmp_val("inverted sync", exp_frame(), host.rx_bits);
    pop_word(PB_WORD);
    cfg.frame_edge_select = 1'b0;
  endtask
  task automatic t_rx_off();
    @(negedge clock);
    cfg.rx_enable = 1'b0;
    host.run_frame(DIN, 1'b0, 0);
    pop_word('0);
    cfg.rx_enable = 1'b1;
  endtask
  task automatic t_shared();
    @(negedge clock);
    tx_cfg.slot[TY_CURR] = 6'h01;
    host.run_frame(DIN, 1'b0, 0);
    cmp_val("shared channel", exp_frame(), host.rx_bits);
    pop_word(PB_WORD);
  endtask
  // Starts from the shared slot setting; the voltage frame is found by its marker bit.
  task automatic t_interleave();
    logic [15:0] got;
    @(negedge clock);
    cfg.sense_interleave_mode = 1'b1;
    host.run_frame(DIN, 1'b0, 0);
    pop_word(PB_WORD);
    if (host.rx_bits[BITS-9] !== 1'b0) begin
      host.run_frame(DIN, 1'b0, 0);
      pop_word(PB_WORD);
    end
    got = host.rx_bits[BITS-9 -: 16];
    cmp_val("voltage frame", {113'h0, tx_words.voltage_sense_word[15:1]}, {112'h0, got});
    host.run_frame(DIN, 1'b0, 0);
    pop_word(PB_WORD);
    got = host.rx_bits[BITS-9 -: 16];
    cmp_val("current frame", {112'h0, 1'b1, tx_words.current_sense_word[15:1]}, {112'h0, got});
    set_base();
  endtask
  task automatic t_fifo_fill();
    int k;
    cmp_val("overflow idle", '0, {127'h0, rx_overflow});
    for (int f = 0; f < 12; f++) host.run_frame(DIN, 1'b0, 0);
    cmp_val("overflow set", 128'h1, {127'h0, rx_overflow});
    k = 0;
    while (playback_valid === 1'b1 && k < 16) begin
      pop_word(PB_WORD);
      k++;
    end
    cmp_val("drained", '0, {127'h0, playback_valid});
  endtask
  // Left-justified, 64 bit clocks a frame: the host call carries two frames, each giving one playback word.
  task automatic t_left_just();
    logic [BITS-1:0] m;
    m = {2{24'hFFFFFF, 8'h00, 32'hFFFFFFFF}};
    @(negedge clock);
    cfg.format = FMT_LEFT;
    cfg.clock_ratio_select = 10'h040;
    cfg.channel_word_size = WS24;
    cfg.extra_bit_drive = 1'b1;
    tx_cfg.enable = 7'h4C;
    tx_cfg.slot = {6'h01, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00, 6'h00};
    host.half_len = 32;
    host.run_frame({2{32'h11111111, 32'h9C35A7FF}}, 1'b1, 0);
    cmp_val("channel drive", m, host.rx_oe);
    cmp_val("channel data", {2{tx_words.dsp_monitor_word[31:8], 40'h0}}, host.rx_bits & m);
    pop_word(32'h9C35A700);
    pop_word(32'h9C35A700);
    host.half_len = 0;
    set_base();
  endtask
  task automatic summarize();
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #320000;
    num_errors++;
    $display("BAD watchdog expected done seen timeout");
    summarize();
  end
  initial begin
    resetn = 1'b0;
    playback_ready = 1'b0;
    num_errors = 0;
    n_tests = 0;
    tx_words = {16'hA5C3, 16'h5A3C, 32'h1234ABCD, 16'h0F1E, 16'h2D3C, 16'h4B5A, 8'hB4};
    set_base();
    repeat (6) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    t_formats();
    t_idle_hiz();
    t_edge_invert();
    t_rx_off();
    t_shared();
    t_interleave();
    t_fifo_fill();
    t_left_just();
    summarize();
  end
endmodule
